//--- hw/mdsp_params.svh
// constants for the motor driver status pin block
`ifndef MDSP_PARAMS_SVH
`define MDSP_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MDSP_OFF_CONFIG     8'h00
`define MDSP_OFF_ALARM_MASK 8'h04
`define MDSP_OFF_STATUS     8'h08
`define MDSP_OFF_COMMAND    8'h0C
`define MDSP_OFF_ADC_OUT    8'h10

// ----------------------------------------------------------------
// config fields
// ----------------------------------------------------------------
`define MDSP_CFG_SWITCH_MODE_BIT    0
`define MDSP_CFG_SYNC_EN    1
`define MDSP_CFG_SYNC_LO    2
`define MDSP_CFG_STEP_LO    5
`define MDSP_CFG_RESET      8'h00
`define MDSP_MASK_RESET     8'hFF

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define MDSP_ST_HIGHZ       0
`define MDSP_ST_BUSY_N      1
`define MDSP_ST_SW_LEVEL    2
`define MDSP_ST_SW_EVENT    3
`define MDSP_ST_POWER_UP    4
`define MDSP_ST_WRONG_CMD   5
`define MDSP_ST_NOT_PERF    6
`define MDSP_ST_UVLO_N      7
`define MDSP_ST_THWRN_N     8
`define MDSP_ST_THSD_N      9
`define MDSP_ST_OCD_N       10

// ----------------------------------------------------------------
// command codes and timing
// ----------------------------------------------------------------
`define MDSP_CMD_RUN        8'h01
`define MDSP_CMD_IMM_STOP   8'h02
`define MDSP_CMD_DEC_STOP   8'h03
`define MDSP_CMD_HIZ        8'h04
`define MDSP_ADC_PERIOD     512

`endif

//--- hw/mdsp_pkg.sv
// types shared by the motor driver status pin block
package mdsp_pkg;
  typedef logic [7:0]  mdsp_cmd_type;
  typedef logic [10:0] mdsp_status_type;
  // alarm sources, one bit each in the mask
  typedef enum logic [2:0]
  {
    ALM_POWER_UP = 3'h0,
    ALM_OCD      = 3'h1,
    ALM_TH_WARN  = 3'h2,
    ALM_THERMAL_SHUTDOWN_BIT    = 3'h3,
    ALM_UVLO     = 3'h4,
    ALM_SW_EVENT = 3'h5,
    ALM_WRONG    = 3'h6,
    ALM_NOT_PERF = 3'h7
  } mdsp_alarm_type;
endpackage : mdsp_pkg

//--- hw/mdsp_rate_div.sv
// free-running divider giving a one-cycle tick every PERIOD cycles
`timescale 1ns/1ps
module mdsp_rate_div
#(
  parameter int PERIOD = 512
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // tick out
  output logic      tick
);
  localparam int CW = $clog2(PERIOD);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      cnt_q <= '0;
    else if (cnt_q == CW'(PERIOD - 1))
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + CW'(1);
  end

  assign tick = (cnt_q == CW'(PERIOD - 1));
endmodule : mdsp_rate_div

//--- hw/mdsp_status_pins.sv
// standby, switch, busy/sync and alarm pin logic with apb registers
`timescale 1ns/1ps
`include "mdsp_params.svh"
module mdsp_status_pins
  import mdsp_pkg::*;
#(
  parameter int ADC_BITS   = 5,
  parameter int ADC_PERIOD = `MDSP_ADC_PERIOD
)
(
  // clock and standby reset
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // switch and converter
  input  wire logic                switchInput,
  input  wire logic [ADC_BITS-1:0] converterSample,
  // protection sensors, high while active
  input  wire logic                overcurrentIn,
  input  wire logic                thermalWarnIn,
  input  wire logic                thermalShutdownIn,
  input  wire logic                undervoltageIn,
  // motion engine
  input  wire logic                cmdExecuting,
  input  wire logic                stepPulse,
  output logic                     motionCmdValid,
  output logic [7:0]               motionCmdCode,
  output logic                     immediateStopReq,
  // power stage
  output logic                     bridgeEnable,
  output logic                     chargePumpRun,
  // open-drain pins, oe low drives low
  output logic                     busyPinOut,
  output logic                     busyPinOeB,
  output logic                     alarmPinOut,
  output logic                     alarmPinOeB
);
  // ----------------------------------------------------------------
  // apb access
  // ----------------------------------------------------------------
  logic [31:0]     prdata_q;
  logic            ready_q;
  logic            accDone;
  logic            wrDone;
  logic            mapped;
  logic [7:0]      config_q;
  logic [7:0]      alarmMask_q;
  logic [ADC_BITS-1:0] adcOut_q;
  mdsp_status_type statusVec;
  logic            statusReadClr;

  always_comb
  begin
    unique case (paddr)
      `MDSP_OFF_CONFIG, `MDSP_OFF_ALARM_MASK, `MDSP_OFF_STATUS,
      `MDSP_OFF_COMMAND, `MDSP_OFF_ADC_OUT: mapped = 1'b1;
      default:                               mapped = 1'b0;
    endcase
  end

  // one wait state so that read data comes from a flip-flop
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      ready_q <= 1'b0;
    else
      ready_q <= psel && penable && !ready_q;
  end

  assign pready  = ready_q;
  assign pslverr = ready_q && !mapped;
  assign accDone = psel && penable && ready_q;
  assign wrDone  = accDone && pwrite && mapped;
  assign prdata  = prdata_q;
  // the status read acts as the status read command
  assign statusReadClr = accDone && !pwrite && (paddr == `MDSP_OFF_STATUS);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      prdata_q <= 32'h0000_0000;
    else if (psel && penable && !ready_q)
    begin
      prdata_q <= 32'h0000_0000;
      if (!pwrite)
      begin
        unique case (paddr)
          `MDSP_OFF_CONFIG:     prdata_q[7:0] <= config_q;
          `MDSP_OFF_ALARM_MASK: prdata_q[7:0] <= alarmMask_q;
          `MDSP_OFF_STATUS:     prdata_q[10:0] <= statusVec;
          `MDSP_OFF_ADC_OUT:    prdata_q[ADC_BITS-1:0] <= adcOut_q;
          default:              prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      config_q    <= `MDSP_CFG_RESET;
      alarmMask_q <= `MDSP_MASK_RESET;
    end
    else if (wrDone && paddr == `MDSP_OFF_CONFIG)
      config_q <= pwdata[7:0];
    else if (wrDone && paddr == `MDSP_OFF_ALARM_MASK)
      alarmMask_q <= pwdata[7:0];
  end

  logic       swMode;
  logic       syncEn;
  logic [2:0] syncSel;
  logic [2:0] stepSel;
  assign swMode  = config_q[`MDSP_CFG_SWITCH_MODE_BIT];
  assign syncEn  = config_q[`MDSP_CFG_SYNC_EN];
  assign syncSel = config_q[`MDSP_CFG_SYNC_LO +: 3];
  assign stepSel = config_q[`MDSP_CFG_STEP_LO +: 3];

  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  logic cmdWrite;
  logic cmdMotion;
  logic cmdHiz;
  logic cmdBlocked;
  assign cmdWrite  = wrDone && (paddr == `MDSP_OFF_COMMAND);
  assign cmdMotion = cmdWrite && (pwdata[7:0] == `MDSP_CMD_RUN ||
                                  pwdata[7:0] == `MDSP_CMD_IMM_STOP ||
                                  pwdata[7:0] == `MDSP_CMD_DEC_STOP);
  assign cmdHiz    = cmdWrite && (pwdata[7:0] == `MDSP_CMD_HIZ);
  // no new motion command under thermal shutdown or undervoltage
  assign cmdBlocked = thermalShutdownIn || undervoltageIn;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      motionCmdValid <= 1'b0;
      motionCmdCode  <= 8'h00;
    end
    else
    begin
      motionCmdValid <= (cmdMotion || cmdHiz) && !cmdBlocked;
      if (cmdMotion || cmdHiz)
        motionCmdCode <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // high impedance and power stage
  // ----------------------------------------------------------------
  logic highZ_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      highZ_q <= 1'b1;
    else if (thermalShutdownIn || cmdHiz)
      highZ_q <= 1'b1;
    else if (cmdMotion && !cmdBlocked)
      highZ_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      chargePumpRun <= 1'b0;
    else
      chargePumpRun <= 1'b1;
  end

  assign bridgeEnable = !highZ_q && !thermalShutdownIn && rst_b;

  // ----------------------------------------------------------------
  // switch input
  // ----------------------------------------------------------------
  logic swPrev_q;
  logic swLevel_q;
  logic swEvent_q;
  logic swFall;

  assign swFall = swPrev_q && !switchInput;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      swPrev_q  <= 1'b1;
      swLevel_q <= 1'b0;
    end
    else
    begin
      swPrev_q  <= switchInput;
      swLevel_q <= !switchInput;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      swEvent_q <= 1'b0;
    else if (swFall)
      swEvent_q <= 1'b1;
    else if (statusReadClr)
      swEvent_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      immediateStopReq <= 1'b0;
    else
      immediateStopReq <= swFall && !swMode;
  end

  // ----------------------------------------------------------------
  // latched alarm conditions, active-low flags held by condition
  // ----------------------------------------------------------------
  logic powerUp_q;
  logic wrongCmd_q;
  logic notPerf_q;
  logic ocdN_q;
  logic thWarnN_q;
  logic thSdN_q;
  logic uvloN_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      powerUp_q  <= 1'b1;
      wrongCmd_q <= 1'b0;
      notPerf_q  <= 1'b0;
    end
    else
    begin
      if (statusReadClr)
        powerUp_q <= 1'b0;
      if (cmdWrite && !cmdMotion && !cmdHiz)
        wrongCmd_q <= 1'b1;
      else if (statusReadClr)
        wrongCmd_q <= 1'b0;
      if (cmdMotion && cmdBlocked)
        notPerf_q <= 1'b1;
      else if (statusReadClr)
        notPerf_q <= 1'b0;
    end
  end

  // sensors ignored in standby since reset holds every flag
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ocdN_q    <= 1'b1;
      thWarnN_q <= 1'b1;
      thSdN_q   <= 1'b1;
      uvloN_q   <= 1'b0;
    end
    else
    begin
      if (overcurrentIn)
        ocdN_q <= 1'b0;
      else if (statusReadClr)
        ocdN_q <= 1'b1;
      if (thermalWarnIn)
        thWarnN_q <= 1'b0;
      else if (statusReadClr)
        thWarnN_q <= 1'b1;
      if (thermalShutdownIn)
        thSdN_q <= 1'b0;
      else if (statusReadClr)
        thSdN_q <= 1'b1;
      if (undervoltageIn)
        uvloN_q <= 1'b0;
      else if (statusReadClr)
        uvloN_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // converter sampling
  // ----------------------------------------------------------------
  logic adcTick;

  mdsp_rate_div #(.PERIOD(ADC_PERIOD)) u_adc_div
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tick     (adcTick)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      adcOut_q <= '0;
    else if (adcTick)
      adcOut_q <= converterSample;
  end

  // ----------------------------------------------------------------
  // busy / sync pin
  // ----------------------------------------------------------------
  logic [15:0] stepCnt_q;
  logic [3:0]  syncIdx;
  logic        busyOeB_q;

  assign syncIdx = {1'b0, syncSel} + {1'b0, stepSel};

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      stepCnt_q <= 16'h0000;
    else if (stepPulse)
      stepCnt_q <= stepCnt_q + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      busyOeB_q <= 1'b1;
    else if (syncEn)
      busyOeB_q <= stepCnt_q[syncIdx];
    else
      busyOeB_q <= !cmdExecuting;
  end

  assign busyPinOut = 1'b0;
  assign busyPinOeB = busyOeB_q;

  // ----------------------------------------------------------------
  // alarm pin
  // ----------------------------------------------------------------
  logic [7:0] alarmPend;
  logic       alarmOeB_q;

  always_comb
  begin
    alarmPend               = 8'h00;
    alarmPend[ALM_POWER_UP] = powerUp_q;
    alarmPend[ALM_OCD]      = !ocdN_q;
    alarmPend[ALM_TH_WARN]  = !thWarnN_q;
    alarmPend[ALM_THERMAL_SHUTDOWN_BIT]    = !thSdN_q;
    alarmPend[ALM_UVLO]     = !uvloN_q;
    alarmPend[ALM_SW_EVENT] = swEvent_q;
    alarmPend[ALM_WRONG]    = wrongCmd_q;
    alarmPend[ALM_NOT_PERF] = notPerf_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      alarmOeB_q <= 1'b1;
    else
      alarmOeB_q <= !(|(alarmPend & alarmMask_q));
  end

  assign alarmPinOut = 1'b0;
  assign alarmPinOeB = alarmOeB_q;

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  always_comb
  begin
    statusVec                     = '0;
    statusVec[`MDSP_ST_HIGHZ]     = highZ_q;
    statusVec[`MDSP_ST_BUSY_N]    = busyOeB_q;
    statusVec[`MDSP_ST_SW_LEVEL]  = swLevel_q;
    statusVec[`MDSP_ST_SW_EVENT]  = swEvent_q;
    statusVec[`MDSP_ST_POWER_UP]  = powerUp_q;
    statusVec[`MDSP_ST_WRONG_CMD] = wrongCmd_q;
    statusVec[`MDSP_ST_NOT_PERF]  = notPerf_q;
    statusVec[`MDSP_ST_UVLO_N]    = uvloN_q;
    statusVec[`MDSP_ST_THWRN_N]   = thWarnN_q;
    statusVec[`MDSP_ST_THSD_N]    = thSdN_q;
    statusVec[`MDSP_ST_OCD_N]     = ocdN_q;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_bridge_off_standby: assert property (@(posedge core_clk)
    !rst_b |-> !bridgeEnable)
    else $error("bridges enabled in standby");

  a_config_reset_value: assert property (@(posedge core_clk)
    !rst_b |=> (config_q == 8'h00 && alarmMask_q == 8'hFF))
    else $error("config not default after standby");

  a_highz_after_reset: assert property (@(posedge core_clk)
    $rose(rst_b) |-> highZ_q && !bridgeEnable)
    else $error("bridges not high-z on standby exit");

  a_motion_exits_hiz: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    (cmdMotion && !cmdBlocked && !cmdHiz) |=> !highZ_q)
    else $error("motion command left high-z set");

  a_switch_level: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    $past(rst_b) |-> swLevel_q == !$past(switchInput))
    else $error("switch level bit stale");

  a_switch_event_hold: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    swFall |=> swEvent_q ##1 (swEvent_q || $past(statusReadClr)))
    else $error("switch event lost");

  a_switch_stop: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    swFall |=> (immediateStopReq == $past(!swMode)))
    else $error("switch stop mode wrong");

  // next tick lands on the eighth cycle at the smallest period
  a_adc_rate: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    adcTick |=> !adcTick [*7])
    else $error("converter sampled too often");

  a_busy_follows: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    (!syncEn && cmdExecuting) ##1 !syncEn |-> !busyPinOeB)
    else $error("busy pin not driven while executing");

  a_alarm_masked: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    $past(rst_b) && ($past(alarmPend & alarmMask_q) == 8'h00)
      |-> alarmPinOeB)
    else $error("masked alarm drove pin");

  a_tsd_status_low: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    thermalShutdownIn |=> !thSdN_q && highZ_q)
    else $error("thermal shutdown not flagged");
endmodule : mdsp_status_pins

//--- bench/mdsp_far_side.sv
// far side model: home switch and motion engine
`timescale 1ns/1ps
`include "mdsp_params.svh"
module mdsp_far_side
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // switch, closed by the bench
  input  wire logic       switchClosed,
  output logic            switchInput,
  // motion engine
  input  wire logic       motionCmdValid,
  input  wire logic [7:0] motionCmdCode,
  input  wire logic       immediateStopReq,
  output logic            cmdExecuting,
  output logic            stepPulse
);
  logic [5:0] runCnt_q;

  // pulled up, so an open switch reads high
  assign switchInput  = ~switchClosed;
  assign cmdExecuting = (runCnt_q != 6'h00);
  assign stepPulse    = cmdExecuting && (runCnt_q[1:0] == 2'h1);

  // a run lasts 40 cycles; any stop ends it at once
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      runCnt_q <= 6'h00;
    else if (immediateStopReq)
      runCnt_q <= 6'h00;
    else if (motionCmdValid)
      runCnt_q <= (motionCmdCode == `MDSP_CMD_RUN) ? 6'h28 : 6'h00;
    else if (cmdExecuting)
      runCnt_q <= runCnt_q - 6'h01;
  end
endmodule : mdsp_far_side

//--- bench/mdsp_status_pins_bench.sv
// self-checking bench for the status pin block
`timescale 1ns/1ps
`include "mdsp_params.svh"
module mdsp_status_pins_bench;
  localparam int PER = 8;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, motionCmdCode, code;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  converterSample;
  logic [3:0]  sens;
  logic        switchClosed, switchInput, cmdExecuting, stepPulse;
  logic        motionCmdValid, immediateStopReq, bridgeEnable;
  logic        chargePumpRun, busyPinOut, busyPinOeB;
  logic        alarmPinOut, alarmPinOeB, lastErr;
  integer      seed = 86;
  int          mismatches, samples_checked, stopCount, stepSeen, s, t;
  int          vldCount;
  int          flagIdx[4] = '{`MDSP_ST_OCD_N, `MDSP_ST_THWRN_N,
                              `MDSP_ST_THSD_N, `MDSP_ST_UVLO_N};

  mdsp_status_pins #(.ADC_BITS(5), .ADC_PERIOD(PER)) mdsp_status_pins_i
  (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .switchInput(switchInput),
    .converterSample(converterSample), .overcurrentIn(sens[0]),
    .thermalWarnIn(sens[1]), .thermalShutdownIn(sens[2]),
    .undervoltageIn(sens[3]), .cmdExecuting(cmdExecuting),
    .stepPulse(stepPulse), .motionCmdValid(motionCmdValid),
    .motionCmdCode(motionCmdCode), .immediateStopReq(immediateStopReq),
    .bridgeEnable(bridgeEnable), .chargePumpRun(chargePumpRun),
    .busyPinOut(busyPinOut), .busyPinOeB(busyPinOeB),
    .alarmPinOut(alarmPinOut), .alarmPinOeB(alarmPinOeB)
  );

  mdsp_far_side mdsp_far_side_i
  (
    .core_clk(core_clk), .rst_b(rst_b), .switchClosed(switchClosed),
    .switchInput(switchInput), .motionCmdValid(motionCmdValid),
    .motionCmdCode(motionCmdCode), .immediateStopReq(immediateStopReq),
    .cmdExecuting(cmdExecuting), .stepPulse(stepPulse)
  );

  // ----------------------------------------------------------------
  // clock, monitors, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      stopCount <= 0;
      stepSeen  <= 0;
      vldCount  <= 0;
    end
    else
    begin
      if (motionCmdValid === 1'b1)
        vldCount <= vldCount + 1;
      if (immediateStopReq === 1'b1)
        stopCount <= stopCount + 1;
      if (stepPulse === 1'b1)
        stepSeen <= stepSeen + 1;
    end
  end

  initial
  begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    close_out();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic syncBit(input int cnt, input int sh);
    logic [31:0] c;
    c = cnt;
    return c[sh];
  endfunction : syncBit

  function automatic logic isBadCmd(input logic [7:0] c);
    return !(c inside {8'h01, 8'h02, 8'h03, 8'h04});
  endfunction : isBadCmd

  function automatic logic isUnmapped(input logic [7:0] a);
    return !(a inside {`MDSP_OFF_CONFIG, `MDSP_OFF_ALARM_MASK,
                       `MDSP_OFF_STATUS, `MDSP_OFF_COMMAND,
                       `MDSP_OFF_ADC_OUT});
  endfunction : isUnmapped

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd      = prdata;
    lastErr = pslverr;
    chk("pslverr", {31'h0, isUnmapped(a)}, {31'h0, lastErr});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset();
    rst_b <= 1'b0;
    tick(20);
    chk1("pump in reset", 1'b0, chargePumpRun);
    chk1("bridge in reset", 1'b0, bridgeEnable);
    chk1("alarm in reset", 1'b1, alarmPinOeB);
    rst_b <= 1'b1;
    tick(4);
  endtask : do_reset

  task automatic close_out();
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {switchClosed, converterSample, sens} = '0;
    rst_b = 1'b0;
    @(posedge core_clk);
    do_reset();
    chk1("pump run", 1'b1, chargePumpRun);
    chk1("alarm powerup", 1'b0, alarmPinOeB);
    chk1("alarm drive", 1'b0, alarmPinOut);
    apb(0, `MDSP_OFF_CONFIG, 0);
    chk("config reset", {24'h0, `MDSP_CFG_RESET}, rd);
    apb(0, `MDSP_OFF_ALARM_MASK, 0);
    chk("mask reset", {24'h0, `MDSP_MASK_RESET}, rd);
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("highz exit", 1'b1, rd[`MDSP_ST_HIGHZ]);
    chk1("powerup flag", 1'b1, rd[`MDSP_ST_POWER_UP]);
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("powerup clear", 1'b0, rd[`MDSP_ST_POWER_UP]);
    tick(3);
    chk1("alarm release", 1'b1, alarmPinOeB);
    apb(1, `MDSP_OFF_COMMAND, {24'h0, `MDSP_CMD_RUN});
    tick(4);
    chk1("bridge on", 1'b1, bridgeEnable);
    chk("cmd count", 1, vldCount);
    chk("cmd code", {24'h0, `MDSP_CMD_RUN}, {24'h0, motionCmdCode});
    chk1("busy pin", 1'b0, busyPinOeB);
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("busy bit", 1'b0, rd[`MDSP_ST_BUSY_N]);
    chk1("highz left", 1'b0, rd[`MDSP_ST_HIGHZ]);
    tick(60);
    chk1("busy done", 1'b1, busyPinOeB);
    // switch closed mid-run in stop mode
    apb(1, `MDSP_OFF_COMMAND, {24'h0, `MDSP_CMD_RUN});
    tick(4);
    switchClosed <= 1'b1;
    tick(6);
    chk("stop pulse", 1, stopCount);
    chk1("busy stopped", 1'b1, busyPinOeB);
    chk1("alarm switch", 1'b0, alarmPinOeB);
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("sw level", 1'b1, rd[`MDSP_ST_SW_LEVEL]);
    chk1("sw event", 1'b1, rd[`MDSP_ST_SW_EVENT]);
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("sw event clr", 1'b0, rd[`MDSP_ST_SW_EVENT]);
    switchClosed <= 1'b0;
    tick(2);
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("sw open", 1'b0, rd[`MDSP_ST_SW_LEVEL]);
    // switch in report-only mode
    apb(1, `MDSP_OFF_CONFIG, 32'h1 << `MDSP_CFG_SWITCH_MODE_BIT);
    switchClosed <= 1'b1;
    tick(4);
    chk("no stop", 1, stopCount);
    switchClosed <= 1'b0;
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("event only", 1'b1, rd[`MDSP_ST_SW_EVENT]);
    // each protection sensor raises and then releases the alarm
    for (int i = 0; i < 4; i++)
    begin
      sens <= 4'h1 << i;
      tick(3);
      chk1("alarm sensor", 1'b0, alarmPinOeB);
      if (i == 3)
        apb(1, `MDSP_OFF_COMMAND, {24'h0, `MDSP_CMD_RUN});
      apb(0, `MDSP_OFF_STATUS, 0);
      chk1("sensor flag", 1'b0, rd[flagIdx[i]]);
      if (i == 2)
      begin
        chk1("thsd bridge", 1'b0, bridgeEnable);
        chk1("thsd highz", 1'b1, rd[`MDSP_ST_HIGHZ]);
      end
      if (i == 3)
        chk1("not performed", 1'b1, rd[`MDSP_ST_NOT_PERF]);
      sens <= 4'h0;
      apb(0, `MDSP_OFF_STATUS, 0);
      tick(3);
      chk1("alarm gone", 1'b1, alarmPinOeB);
    end
    // both stop commands also leave high impedance
    apb(1, `MDSP_OFF_COMMAND, {24'h0, `MDSP_CMD_IMM_STOP});
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("imm stop exit", 1'b0, rd[`MDSP_ST_HIGHZ]);
    apb(1, `MDSP_OFF_COMMAND, {24'h0, `MDSP_CMD_HIZ});
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("hiz command", 1'b1, rd[`MDSP_ST_HIGHZ]);
    apb(1, `MDSP_OFF_COMMAND, {24'h0, `MDSP_CMD_DEC_STOP});
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("dec stop exit", 1'b0, rd[`MDSP_ST_HIGHZ]);
    // a random bad code, then the same code masked
    do code = 8'($random(seed)); while (!isBadCmd(code));
    apb(1, `MDSP_OFF_COMMAND, {24'h0, code});
    tick(3);
    chk1("alarm wrong", 1'b0, alarmPinOeB);
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("wrong flag", 1'b1, rd[`MDSP_ST_WRONG_CMD]);
    tick(3);
    chk1("wrong release", 1'b1, alarmPinOeB);
    apb(1, `MDSP_OFF_ALARM_MASK, 32'hBF);
    apb(1, `MDSP_OFF_COMMAND, {24'h0, code});
    tick(3);
    chk1("masked alarm", 1'b1, alarmPinOeB);
    apb(0, `MDSP_OFF_STATUS, 0);
    chk1("masked flag", 1'b1, rd[`MDSP_ST_WRONG_CMD]);
    repeat (4)
    begin
      converterSample <= 5'($random(seed));
      tick(2 * PER + 2);
      apb(0, `MDSP_OFF_ADC_OUT, 0);
      chk("adc out", {27'h0, converterSample}, rd);
    end
    // step clock on the busy pin
    s = $unsigned($random(seed)) % 2;
    t = $unsigned($random(seed)) % 2;
    apb(1, `MDSP_OFF_CONFIG, 32'h2 | (s << 2) | (t << 5));
    apb(1, `MDSP_OFF_COMMAND, {24'h0, `MDSP_CMD_RUN});
    tick(50);
    chk1("sync pin", syncBit(stepSeen, s + t), busyPinOeB);
    chk1("busy drive", 1'b0, busyPinOut);
    apb(0, 8'h20, 0);
    chk1("unmapped err", 1'b1, lastErr);
    chk("unmapped data", 0, rd);
    // high-z before reset, then defaults again
    apb(1, `MDSP_OFF_COMMAND, {24'h0, `MDSP_CMD_HIZ});
    apb(1, `MDSP_OFF_CONFIG, 32'hFF);
    chk1("hiz before reset", 1'b0, bridgeEnable);
    do_reset();
    apb(0, `MDSP_OFF_CONFIG, 0);
    chk("config again", {24'h0, `MDSP_CFG_RESET}, rd);
    apb(0, `MDSP_OFF_ALARM_MASK, 0);
    chk("mask again", {24'h0, `MDSP_MASK_RESET}, rd);
    close_out();
  end
endmodule : mdsp_status_pins_bench
